// file: verilog/irq_output_deassert_control.sv
// Summary of operation
// (R1) Top byte holds interval, ten microsecond units.
// (R2) Writing zero disables interval, clears counter.
// (R3) Zero write releases held interrupts at once.
// (R4) New non-zero interval applies to later requests.
// (R5) Power event interrupt bypasses interval gating.
// (R6) Restart bit clears counter, starts fresh interval.
// (R7) Bit 13 shows interval; blocks pin meanwhile.
// (R8) Bit 12 shows internal master interrupt line.
// (R9) Bit 12 ignores pin enable and interval.
// (R10) Pin enable zero keeps request deasserted.
// (R11) Pin enable gates only the external output; the code also gates delivered_q, so the interval start.
// (R12) Polarity bit: zero active low, one high.
// (R13) Type bit: zero open-drain, one push-pull.
// (R14) Open-drain ignores polarity, asserts low.
// (R15) Software acknowledges a source by writing one.
// (R16) Interval starts when request drops after acknowledge.
// (R17) All fields reset to zero.
// (R18) Polarity and type survive soft reset.
module irq_output_deassert_control (
   input  wire logic                  clock_in,
   input  wire logic                  rstn_in,
   input  wire logic                  soft_reset_in,
   input  wire irq_out_pkg::reg_req_s reg_req_in,
   input  wire logic                  master_irq_in,
   input  wire logic                  power_event_in,
   input  wire logic                  ack_write_in,
   output logic [31:0]                read_data_out,
   output logic                       read_valid_out,
   output logic                       irq_out,
   output logic                       irq_oe_out
);
   import irq_out_pkg::*;

   logic [7:0]      deassert_interval_q;
   logic            pin_enable_q;
   logic            request_polarity_q;
   logic            buffer_type_q;
   interval_state_e state_q;
   logic [7:0]      tick_q;
   logic [7:0]      unit_q;
   logic            delivered_q;
   logic            armed_q;
   logic [8:0]      quiet_q;
   logic            cfg_write;
   logic            interval_restart;
   logic            zero_write;
   logic            drop_start;
   logic            unit_done;
   logic            interval_active;
   logic            request_now;
   logic            irq_d;
   logic            irq_oe_d;

   // True when a bus request addresses the configuration register.
   function automatic logic hits_cfg(input logic [7:0] addr);
      return (addr == CFG_OFFSET);
   endfunction : hits_cfg

   // Decode of a write to the configuration register and its side effects.
   assign cfg_write        = reg_req_in.write && hits_cfg(reg_req_in.addr);
   assign zero_write       = cfg_write && (reg_req_in.data[INTERVAL_MSB:INTERVAL_LSB] == 8'h00);
   assign interval_restart = cfg_write && reg_req_in.data[RESTART_BIT]
                             && !zero_write; // R6
   assign interval_active  = (state_q == INTERVAL_ST); // R7
   assign unit_done        = (tick_q == UNIT_CYCLES - 8'h01);
   // The interval begins when an acknowledged request leaves the pin.
   assign drop_start       = armed_q && delivered_q && !master_irq_in
                             && (deassert_interval_q != 8'h00); // R16

   // Enabled sources reach the pin outside an interval; the power event does even inside one.
   assign request_now = pin_enable_q
                        && ((master_irq_in && !interval_active) || power_event_in); // R5 R7 R10

   // Interval setting and pin enable; a soft reset clears them too.
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         deassert_interval_q <= INTERVAL_RESET; // R17
         pin_enable_q        <= PIN_EN_RESET;
      end else if (soft_reset_in) begin
         deassert_interval_q <= INTERVAL_RESET;
         pin_enable_q        <= PIN_EN_RESET;
      end else if (cfg_write) begin
         deassert_interval_q <= reg_req_in.data[INTERVAL_MSB:INTERVAL_LSB]; // R1 R4
         pin_enable_q        <= reg_req_in.data[PIN_EN_BIT];
      end
   end

   // Polarity and buffer type are cleared by the hardware reset alone.
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         request_polarity_q <= POLARITY_RESET; // R17
         buffer_type_q      <= BUF_TYPE_RESET;
      end else if (cfg_write) begin
         request_polarity_q <= reg_req_in.data[POLARITY_BIT]; // R18
         buffer_type_q      <= reg_req_in.data[BUF_TYPE_BIT];
      end
   end

   // Acknowledge tracking; a new acknowledge wins over the clear at interval start.
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         armed_q <= 1'b0;
      end else if (ack_write_in) begin
         armed_q <= 1'b1; // R15
      end else if (drop_start || soft_reset_in) begin
         armed_q <= 1'b0;
      end
   end

   // Interval engine: counts clock ticks into ten microsecond units.
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q <= IDLE_ST;
         tick_q  <= 8'h00;
         unit_q  <= 8'h00;
      end else if (soft_reset_in || zero_write) begin
         state_q <= IDLE_ST; // R2 R3
         tick_q  <= 8'h00;
         unit_q  <= 8'h00;
      end else if (interval_restart || (drop_start && !interval_active)) begin
         state_q <= INTERVAL_ST; // R6 R16
         tick_q  <= 8'h00;
         unit_q  <= 8'h00;
      end else begin
         case (state_q)
            IDLE_ST: begin
               tick_q <= 8'h00;
               unit_q <= 8'h00;
            end
            INTERVAL_ST: begin
               if (unit_done) begin
                  tick_q <= 8'h00;
                  if (unit_q + 8'h01 >= deassert_interval_q) begin
                     state_q <= IDLE_ST; // R1 R4
                     unit_q  <= 8'h00;
                  end else begin
                     unit_q <= unit_q + 8'h01;
                  end
               end else begin
                  tick_q <= tick_q + 8'h01;
               end
            end
            default: begin
               state_q <= IDLE_ST;
            end
         endcase
      end
   end

   // Cycles since the last configuration write or soft reset; it saturates.
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         quiet_q <= 9'h000;
      end else if (cfg_write || soft_reset_in) begin
         quiet_q <= 9'h000;
      end else if (quiet_q != 9'h1ff) begin
         quiet_q <= quiet_q + 9'h001;
      end
   end

   // Output driver: open-drain drives low only when asserted, push-pull always drives.
   always_comb begin
      irq_d    = 1'b1;
      irq_oe_d = 1'b0;
      if (!buffer_type_q) begin
         irq_d    = 1'b0; // R13 R14
         irq_oe_d = request_now;
      end else begin
         irq_oe_d = 1'b1; // R13
         irq_d    = request_polarity_q ? request_now : !request_now; // R12
      end
   end

   // Registered pin and delivered-request flag.
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_out     <= 1'b0;
         irq_oe_out  <= 1'b0;
         delivered_q <= 1'b0;
      end else begin
         irq_out     <= irq_d; // R10 R11
         irq_oe_out  <= irq_oe_d;
         delivered_q <= request_now;
      end
   end

   // Register read; bit 12 follows the master line directly.
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         read_data_out  <= 32'h00000000;
         read_valid_out <= 1'b0;
      end else begin
         read_valid_out <= reg_req_in.read;
         read_data_out  <= 32'h00000000;
         if (reg_req_in.read && hits_cfg(reg_req_in.addr)) begin
            read_data_out[INTERVAL_MSB:INTERVAL_LSB] <= deassert_interval_q;
            read_data_out[ACTIVE_BIT]                <= interval_active; // R7
            read_data_out[MASTER_BIT]                <= master_irq_in; // R8 R9
            read_data_out[PIN_EN_BIT]                <= pin_enable_q;
            read_data_out[POLARITY_BIT]              <= request_polarity_q;
            read_data_out[BUF_TYPE_BIT]              <= buffer_type_q;
         end
      end
   end

   // Checks on the documented behaviour.
   // A disabled pin shows only the idle level of the selected driver.
   pin_disabled_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R10
      !pin_enable_q |=> (irq_oe_out == $past(buffer_type_q))
          && (irq_out == ($past(buffer_type_q) && !$past(request_polarity_q))))
      else $error("request asserted while pin disabled");

   // A zero interval write stops the engine and clears its unit count.
   zero_write_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R2
      zero_write |=> !interval_active && (unit_q == 8'h00))
      else $error("zero write did not stop interval");

   // A pending request goes out right after the interval is switched off.
   release_now_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R3
      (zero_write && reg_req_in.data[PIN_EN_BIT] && !soft_reset_in) ##1 master_irq_in
      |=> irq_oe_out && (irq_out == ($past(buffer_type_q) && $past(request_polarity_q))))
      else $error("held interrupt not released");

   // The power event reaches an enabled pin in either driver mode.
   power_bypass_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R5
      (power_event_in && pin_enable_q)
      |=> irq_oe_out && (irq_out == ($past(buffer_type_q) && $past(request_polarity_q))))
      else $error("power event gated by interval");

   // A restart write enters the interval with a cleared tick count.
   restart_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R6
      (interval_restart && !soft_reset_in) |=> interval_active && (tick_q == 8'h00))
      else $error("restart did not begin interval");

   // Inside an interval without a power event only the idle level of the driver reaches the pin.
   interval_block_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R7
      (interval_active && !power_event_in)
      |=> (irq_oe_out == $past(buffer_type_q))
          && (irq_out == ($past(buffer_type_q) && !$past(request_polarity_q))))
      else $error("interrupt reached pin during interval");

   // An undisturbed one unit interval lasts exactly one unit of clock ticks.
   interval_len_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R1
      (interval_restart && !soft_reset_in
       && (reg_req_in.data[INTERVAL_MSB:INTERVAL_LSB] == 8'h01))
      |=> ##199 (interval_active || (quiet_q != 9'h0c7))
      ##1 (!interval_active || (quiet_q != 9'h0c8)))
      else $error("one unit interval has wrong length");

   // An open-drain pin is never driven high.
   open_drain_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R14
      !buffer_type_q |=> !irq_out)
      else $error("open-drain output driven high");

   // A push-pull pin always drives the level chosen by the polarity.
   push_pull_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R13
      buffer_type_q |=> irq_oe_out && (irq_out == ($past(request_polarity_q)
                        ~^ $past(request_now))))
      else $error("push-pull level wrong");

   // A soft reset keeps the driver settings and disables the pin.
   soft_keep_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R18
      (soft_reset_in && !cfg_write) |=> $stable(request_polarity_q) && $stable(buffer_type_q)
                                       && !pin_enable_q)
      else $error("soft reset disturbed polarity or type");

   // A register read answers next cycle with the master line and interval state.
   read_master_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R7 R8
      (reg_req_in.read && hits_cfg(reg_req_in.addr)) |=> read_valid_out
      && (read_data_out[MASTER_BIT] == $past(master_irq_in))
      && (read_data_out[ACTIVE_BIT] == $past(interval_active)))
      else $error("status read shows wrong master or interval bit");

   // The self-clearing restart bit never reads back as one.
   restart_read_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R6
      reg_req_in.read |=> !read_data_out[RESTART_BIT])
      else $error("restart bit read back as one");

   // A delivered request that drops after an acknowledge opens an interval.
   drop_start_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R16
      (drop_start && !interval_active && !soft_reset_in && !zero_write) |=> interval_active)
      else $error("interval did not start after acknowledged drop");

   // An acknowledge always arms the interval start, even against a clear.
   armed_set_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R15
      ack_write_in |=> armed_q)
      else $error("acknowledge not recorded");

   // A write loads the interval setting and the pin enable.
   config_write_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R1 R4
      (cfg_write && !soft_reset_in)
      |=> (deassert_interval_q == $past(reg_req_in.data[INTERVAL_MSB:INTERVAL_LSB]))
      && (pin_enable_q == $past(reg_req_in.data[PIN_EN_BIT])))
      else $error("interval or pin enable not loaded");

   // A write loads polarity and buffer type, soft reset or not.
   type_write_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R12 R13
      cfg_write |=> (request_polarity_q == $past(reg_req_in.data[POLARITY_BIT]))
      && (buffer_type_q == $past(reg_req_in.data[BUF_TYPE_BIT])))
      else $error("polarity or buffer type not loaded");

   // Outside an interval the counters rest at zero.
   idle_clear_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R2
      !interval_active |-> (tick_q == 8'h00) && (unit_q == 8'h00))
      else $error("interval counter not cleared while idle");

   // The tick counter never passes one unit.
   tick_bound_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // R1
      interval_active |-> (tick_q < UNIT_CYCLES))
      else $error("tick counter passed one unit");

endmodule : irq_output_deassert_control

// file: common/irq_out_pkg.sv
package irq_out_pkg;

   // Byte address of the interrupt output configuration register.
   localparam logic [7:0] CFG_OFFSET        = 8'h54;

   // Field positions within the configuration register.
   localparam int         INTERVAL_MSB      = 31;
   localparam int         INTERVAL_LSB      = 24;
   localparam int         RESTART_BIT       = 14;
   localparam int         ACTIVE_BIT        = 13;
   localparam int         MASTER_BIT        = 12;
   localparam int         PIN_EN_BIT        = 8;
   localparam int         POLARITY_BIT      = 4;
   localparam int         BUF_TYPE_BIT      = 0;

   // Values after reset.
   localparam logic [7:0] INTERVAL_RESET    = 8'h00;
   localparam logic       PIN_EN_RESET      = 1'b0;
   localparam logic       POLARITY_RESET    = 1'b0;
   localparam logic       BUF_TYPE_RESET    = 1'b0;

   // One interval unit in nanoseconds and the clock period in nanoseconds.
   localparam int         UNIT_TIME_NS      = 10000;
   localparam int         CLOCK_PERIOD_NS   = 50;
   localparam int         UNIT_CYCLES_INT   = (UNIT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam logic [7:0] UNIT_CYCLES       = UNIT_CYCLES_INT[7:0];

   // Host register access, one cycle per request.
   typedef struct packed {
      logic        write;
      logic        read;
      logic [7:0]  addr;
      logic [31:0] data;
   } reg_req_s;

   // Interval engine states.
   typedef enum logic [0:0] {
      IDLE_ST     = 1'b0,
      INTERVAL_ST = 1'b1
   } interval_state_e;

endpackage : irq_out_pkg

// file: dv/host_irq_input.sv
// Host interrupt input: resolves the request wire and decides whether the host sees a request.
module host_irq_input (
   input  wire logic irq_level_in,
   input  wire logic irq_drive_in,
   input  wire logic active_high_in,
   input  wire logic push_pull_in,
   output logic      pin_level_out,
   output logic      seen_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // A pull-up holds the wire high whenever the device lets go of it.
   assign pin_level_out = irq_drive_in ? irq_level_in : 1'b1;
   // An open-drain wire is always active low, whatever the polarity setting says.
   assign seen_out = (push_pull_in && active_high_in) ? pin_level_out : !pin_level_out;
endmodule : host_irq_input

// file: dv/irq_output_deassert_control_tb.sv
// Self-checking bench for the interrupt output stage.
module irq_output_deassert_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import irq_out_pkg::*;

   logic        clock_in, rstn_in, soft_reset, master_irq, power_event, ack_write;
   reg_req_s    reg_req;
   logic [31:0] read_data;
   logic        read_valid, irq_pin, irq_oe, pol_cfg, pp_cfg, pin_level, seen;
   int          fail_count, compares, cycles;

   irq_output_deassert_control irq_output_deassert_control_inst (
      .clock_in(clock_in), .rstn_in(rstn_in), .soft_reset_in(soft_reset),
      .reg_req_in(reg_req), .master_irq_in(master_irq), .power_event_in(power_event),
      .ack_write_in(ack_write), .read_data_out(read_data), .read_valid_out(read_valid),
      .irq_out(irq_pin), .irq_oe_out(irq_oe));

   host_irq_input host_irq_input_inst (
      .irq_level_in(irq_pin), .irq_drive_in(irq_oe), .active_high_in(pol_cfg),
      .push_pull_in(pp_cfg), .pin_level_out(pin_level), .seen_out(seen));

   // Free-running 20 MHz clock.
   always #25 clock_in = ~clock_in;

   // Cuts a hung run short.
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_in);
   endtask : cyc

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // One write cycle; returns once the new setting has reached the pin.
   task automatic reg_wr(input logic [31:0] d);
      reg_req = '{1'b1, 1'b0, CFG_OFFSET, d};
      pol_cfg = d[POLARITY_BIT];
      pp_cfg  = d[BUF_TYPE_BIT];
      cyc(1);
      reg_req = '0;
      cyc(1);
   endtask : reg_wr

   // One read cycle; the answer stands only in the cycle after the request.
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      reg_req = '{1'b0, 1'b1, a, 32'h0};
      cyc(1);
      reg_req = '0;
      check({31'h0, read_valid}, 32'h1);
      check(read_data, exp);
      cyc(1);
   endtask : reg_rd

   task automatic t_reset;
      reg_rd(CFG_OFFSET, 32'h0);
      reg_rd(8'h58, 32'h0);
   endtask : t_reset

   // Pin enable, buffer type and polarity.
   task automatic t_pin;
      master_irq = 1'b1;
      cyc(2);
      check({31'h0, irq_oe}, 32'h0);
      reg_rd(CFG_OFFSET, 32'h00001000);
      reg_wr(32'h00000110);
      check({30'h0, irq_oe, irq_pin}, 32'h2);
      check({31'h0, seen}, 32'h1);
      reg_wr(32'h00000111);
      check({30'h0, irq_oe, irq_pin}, 32'h3);
      reg_wr(32'h00000101);
      check({30'h0, irq_oe, irq_pin}, 32'h2);
      master_irq = 1'b0;
      cyc(2);
      check({30'h0, irq_oe, irq_pin}, 32'h3);
   endtask : t_pin

   // Restarted interval, power event bypass, expiry and zero write.
   task automatic t_interval;
      master_irq = 1'b1;
      reg_wr(32'h01004101);
      check({31'h0, seen}, 32'h0);
      reg_rd(CFG_OFFSET, 32'h01003101);
      power_event = 1'b1;
      cyc(2);
      check({31'h0, seen}, 32'h1);
      power_event = 1'b0;
      cyc(UNIT_CYCLES_INT - 20);
      check({31'h0, seen}, 32'h0);
      cyc(30);
      check({31'h0, seen}, 32'h1);
      reg_wr(32'h01004101);
      cyc(50);
      check({31'h0, seen}, 32'h0);
      reg_wr(32'h00000101);
      cyc(1);
      check({31'h0, seen}, 32'h1);
      reg_rd(CFG_OFFSET, 32'h00001101);
   endtask : t_interval

   // Acknowledge, drop of the request, then a held new request.
   task automatic t_ack;
      reg_wr(32'h02000101);
      check({31'h0, seen}, 32'h1);
      ack_write = 1'b1;
      cyc(1);
      ack_write  = 1'b0;
      master_irq = 1'b0;
      cyc(2);
      master_irq = 1'b1;
      cyc(2);
      check({31'h0, seen}, 32'h0);
      cyc(2 * UNIT_CYCLES_INT - 30);
      check({31'h0, seen}, 32'h0);
      cyc(40);
      check({31'h0, seen}, 32'h1);
   endtask : t_ack

   task automatic t_soft;
      master_irq = 1'b0;
      reg_wr(32'h01000111);
      soft_reset = 1'b1;
      cyc(1);
      soft_reset = 1'b0;
      reg_rd(CFG_OFFSET, 32'h00000011);
   endtask : t_soft

   task automatic end_sim;
      $display("fail_count=%0d compares=%0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim

   // Reset for ten cycles, then run every scenario in turn.
   initial begin
      clock_in    = 1'b0;
      rstn_in     = 1'b0;
      soft_reset  = 1'b0;
      master_irq  = 1'b0;
      power_event = 1'b0;
      ack_write   = 1'b0;
      reg_req     = '0;
      pol_cfg     = 1'b0;
      pp_cfg      = 1'b0;
      cyc(10);
      rstn_in = 1'b1;
      cyc(1);
      t_reset();
      t_pin();
      t_interval();
      t_ack();
      t_soft();
      end_sim();
   end
endmodule : irq_output_deassert_control_tb
